// ### rtl/ctl_link.sv
// link relay exchange engine: unit number capture, slot polling, image update
`include "ctl_map.svh"
module ctl_link (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // core side
   ctl_relay_if.link        rly,
   // synchronised link pins
   input  wire logic [1:0]  unit_s,
   input  wire logic        stb_s,
   input  wire logic [1:0]  sel_s,
   input  wire logic        ack_s,
   input  wire logic [31:0] dat_s,
   // link pin drivers
   output logic             stb_o,
   output logic             stb_oe,
   output logic [1:0]       sel_o,
   output logic             sel_oe,
   output logic             ack_o,
   output logic             ack_oe,
   output logic [31:0]      dat_o,
   output logic             dat_oe
);
   ctl_pkg::ctl_lk_e st_r, st_nxt;
   logic [2:0]  cap_r, cap_nxt;
   logic [1:0]  unit_nxt, sel_nxt;
   logic        ackp_r, stb_nxt, ack_nxt, dat_oe_nxt, ok_nxt;
   logic [12:0] to_r, to_nxt;
   logic [31:0] dat_nxt;
   ctl_pkg::ctl_word_t [3:0] img_nxt;
   logic        ack_rise, match;
   assign ack_rise = ack_s && !ackp_r;
   assign match    = stb_s && (sel_s == rly.unit) && (cap_r == `CTL_CAP_CYC);
   always_comb begin
      cap_nxt = cap_r;
      unit_nxt = rly.unit;
      st_nxt = st_r;
      sel_nxt = sel_o;
      stb_nxt = stb_o;
      img_nxt = rly.img;
      to_nxt = to_r;
      if (cap_r != `CTL_CAP_CYC) begin
         cap_nxt  = cap_r + 3'h1;
         unit_nxt = unit_s;
      end
      dat_oe_nxt = match;
      dat_nxt    = match ? rly.own : '0;
      ack_nxt    = match && dat_oe;
      if (ack_rise) begin
         img_nxt[sel_s] = dat_s;
      end
      if (rly.master && cap_r == `CTL_CAP_CYC) begin
         case (st_r)
            ctl_pkg::LK_IDLE: begin
               if (rly.tick) begin
                  st_nxt  = ctl_pkg::LK_REQ;
                  stb_nxt = 1'b1;
                  sel_nxt = 2'h0;
               end
            end
            ctl_pkg::LK_REQ: begin
               if (ack_s) begin
                  st_nxt  = ctl_pkg::LK_REL;
                  stb_nxt = 1'b0;
               end
            end
            ctl_pkg::LK_REL: begin
               if (!ack_s) begin
                  sel_nxt = sel_o + 2'h1;
                  if (sel_o == 2'(`CTL_UNITS - 1)) begin
                     st_nxt = ctl_pkg::LK_IDLE;
                  end else begin
                     st_nxt  = ctl_pkg::LK_REQ;
                     stb_nxt = 1'b1;
                  end
               end
            end
            default: st_nxt = ctl_pkg::LK_IDLE;
         endcase
      end
      if (ack_rise) begin
         to_nxt = '0;
      end else if (to_r != 13'(`CTL_LTO_CYC)) begin
         to_nxt = to_r + 13'h1;
      end
      ok_nxt = to_r != 13'(`CTL_LTO_CYC);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_r     <= '0;
         rly.unit  <= '0;
         st_r      <= ctl_pkg::LK_IDLE;
         sel_o     <= '0;
         stb_o     <= 1'b0;
         ack_o     <= 1'b0;
         dat_o     <= '0;
         dat_oe    <= 1'b0;
         ackp_r    <= 1'b0;
         rly.img    <= '0;
         to_r       <= 13'(`CTL_LTO_CYC);
         rly.ok     <= 1'b0;
         rly.master <= 1'b0;
      end else begin
         cap_r     <= cap_nxt;
         rly.unit  <= unit_nxt;
         st_r      <= st_nxt;
         sel_o     <= sel_nxt;
         stb_o     <= stb_nxt;
         ack_o     <= ack_nxt;
         dat_o     <= dat_nxt;
         dat_oe    <= dat_oe_nxt;
         ackp_r    <= ack_s;
         rly.img    <= img_nxt;
         to_r       <= to_nxt;
         rly.ok     <= ok_nxt;
         rly.master <= (cap_nxt == `CTL_CAP_CYC) && (unit_nxt == 2'h0);
      end
   end
   assign stb_oe = rly.master;
   assign sel_oe = rly.master;
   assign ack_oe = ack_o;
   a_unit_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (cap_r == `CTL_CAP_CYC) |=> $stable(rly.unit)) else $error("unit number changed after capture");
   a_master_only: assert property (@(posedge aclk) disable iff (!aresetn)
      stb_o |-> rly.master) else $error("non-master drove the link strobe");
   a_img_update: assert property (@(posedge aclk) disable iff (!aresetn)
      ack_rise |=> rly.img[$past(sel_s)] == $past(dat_s)) else $error("link image missed a slot word");
endmodule : ctl_link

// ### rtl/ctl_lr_if.sv
// link relay image exchanged between core and link engine
interface ctl_relay_if;
   ctl_pkg::ctl_word_t        own;
   ctl_pkg::ctl_word_t [3:0]  img;
   logic                      tick;
   logic                      ok;
   logic                      master;
   logic [1:0]                unit;
   modport link (input own, input tick, output img, output ok, output master, output unit);
   modport core (output own, output tick, input img, input ok, input master, input unit);
endinterface : ctl_relay_if

// ### rtl/ctl_map.svh
// register map, field positions and timing counts of the controller core
`ifndef CTL_MAP_SVH
`define CTL_MAP_SVH
`define CTL_A_CTRL     8'h00
`define CTL_A_STAT     8'h04
`define CTL_A_IN       8'h08
`define CTL_A_OUT      8'h0C
`define CTL_A_DRUM     8'h10
`define CTL_A_LROWN    8'h14
`define CTL_A_LR0      8'h18
`define CTL_A_LR3      8'h24
`define CTL_A_ISTAT    8'h28
`define CTL_A_IMASK    8'h2C
`define CTL_F_RUN      0
`define CTL_F_DRUM     1
`define CTL_F_VAR      2
`define CTL_S_ERR      0
`define CTL_S_LINK     1
`define CTL_S_MST      2
`define CTL_S_UNIT     4
`define CTL_E_INCHG    0
`define CTL_E_DRUMRST  1
`define CTL_E_ERR      2
`define CTL_E_LINKLOST 3
`define CTL_VAR_SMALL  2'h0
`define CTL_VAR_MID    2'h1
`define CTL_CLK_NS     10
`define CTL_SCAN_NS    10000
`define CTL_SCAN_CYC   (`CTL_SCAN_NS / `CTL_CLK_NS)
`define CTL_LTO_NS     40960
`define CTL_LTO_CYC    (`CTL_LTO_NS / `CTL_CLK_NS)
`define CTL_UNITS      4
`define CTL_RELAY_W    32
`define CTL_NIN        12
`define CTL_NOUT       8
`define CTL_CAP_CYC    3'h6
`endif

// ### rtl/ctl_pkg.sv
// types shared by the controller core
package ctl_pkg;
   typedef enum logic [2:0] {
      LK_IDLE = 3'b001,
      LK_REQ  = 3'b010,
      LK_REL  = 3'b100
   } ctl_lk_e;
   typedef logic [31:0] ctl_word_t;
endpackage : ctl_pkg

// ### rtl/ctl_sync.sv
// three-stage input synchroniser, change taken when stages two and three agree
module ctl_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_nxt;
   always_comb begin
      // each bit on its own: a wandering neighbour must not freeze the rest
      q_nxt = (q & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q    <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= q_nxt;
      end
   end
endmodule : ctl_sync

// ### rtl/ctl_top.sv
// controller core: i/o image scan, drum counter, indicators, link relay, axi4-lite registers
// Overview of operation
// - Every scan the input points are sampled into the input image bits.
// - Every scan in run mode without a fault the output points are driven from the output image bits.
// - With the drum counter enabled, point 0 counts and point 1 resets the counter.
// - The run lamp is lit only in run mode without a fault.
// - The link lamp is lit only while link exchange is healthy.
// - A diagnosed fault lights the error lamp and stops program operation.
// - The variant fixes 6/4, 10/6 or 12/8 input and output points.
// - Four units share 128 link relay bits, 32 from each.
// - Each unit runs alone while link relay words move without software transfers.
// - The unit number 0 to 3 is taken from the adapter connector at power-on.
// - Unit zero is link master and runs all link transfers.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`include "ctl_map.svh"
module ctl_top (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // field points and lamps
   input  wire logic [11:0] in_pt,
   output logic [7:0]       out_pt,
   input  wire logic        diag_fault,
   output logic             led_run,
   output logic             led_link,
   output logic             led_err,
   output logic             irq,
   // link adapter pins
   input  wire logic [1:0]  unit_pin,
   input  wire logic        lk_stb_i,
   output logic             lk_stb_o,
   output logic             lk_stb_oe,
   input  wire logic [1:0]  lk_sel_i,
   output logic [1:0]       lk_sel_o,
   output logic             lk_sel_oe,
   input  wire logic        lk_ack_i,
   output logic             lk_ack_o,
   output logic             lk_ack_oe,
   input  wire logic [31:0] lk_dat_i,
   output logic [31:0]      lk_dat_o,
   output logic             lk_dat_oe
);
   ctl_relay_if rly ();
   logic [11:0] in_s;
   logic [1:0]  unit_s, sel_s;
   logic        diag_s, stb_s, ack_s;
   logic [31:0] dat_s;
   ctl_sync #(.W(12)) u_sin (.aclk(aclk), .aresetn(aresetn), .d(in_pt), .q(in_s));
   ctl_sync #(.W(39)) u_slk (.aclk(aclk), .aresetn(aresetn),
      .d({unit_pin, lk_stb_i, lk_sel_i, lk_ack_i, lk_dat_i, diag_fault}),
      .q({unit_s, stb_s, sel_s, ack_s, dat_s, diag_s}));
   ctl_link u_link (.aclk(aclk), .aresetn(aresetn), .rly(rly), .unit_s(unit_s), .stb_s(stb_s),
      .sel_s(sel_s), .ack_s(ack_s), .dat_s(dat_s), .stb_o(lk_stb_o), .stb_oe(lk_stb_oe),
      .sel_o(lk_sel_o), .sel_oe(lk_sel_oe), .ack_o(lk_ack_o), .ack_oe(lk_ack_oe),
      .dat_o(lk_dat_o), .dat_oe(lk_dat_oe));

   // points present in each variant
   function automatic logic [11:0] in_mask(input logic [1:0] v);
      if (v == `CTL_VAR_SMALL) return 12'h03F;
      else if (v == `CTL_VAR_MID) return 12'h3FF;
      else return 12'hFFF;
   endfunction : in_mask
   function automatic logic [7:0] out_mask(input logic [1:0] v);
      if (v == `CTL_VAR_SMALL) return 8'h0F;
      else if (v == `CTL_VAR_MID) return 8'h3F;
      else return 8'hFF;
   endfunction : out_mask
   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) o[i*8 +: 8] = d[i*8 +: 8];
      end
      return o;
   endfunction : wmerge

   // register state
   logic [3:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  oimg_r, oimg_nxt, out_nxt;
   logic [11:0] iimg_r, iimg_nxt;
   logic [15:0] drum_r, drum_nxt;
   logic [31:0] own_r, own_nxt;
   logic [3:0]  ist_r, ist_nxt, imask_r, imask_nxt, ev;
   logic        err_r, err_nxt, okp_r, d0p_r, d1p_r;
   logic [9:0]  scan_r, scan_nxt;
   logic        tick;
   // bus state
   logic        aw_r, aw_nxt, w_r, w_nxt, bv_nxt, rv_nxt;
   logic [7:0]  awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt, rd_nxt, wv;
   logic [3:0]  ws_r, ws_nxt;
   logic [1:0]  br_nxt, rr_nxt;
   logic        do_wr;

   assign tick  = scan_r == '0;
   assign do_wr = aw_r && w_r && !s_axi_bvalid;
   assign rly.own  = own_r;
   assign rly.tick = tick;

   // scan, drum counter, lamps, events
   always_comb begin
      scan_nxt = tick ? 10'(`CTL_SCAN_CYC - 1) : scan_r - 10'h1;
      iimg_nxt = iimg_r;
      out_nxt  = out_pt;
      drum_nxt = drum_r;
      err_nxt  = err_r || diag_s;
      ev       = '0;
      if (tick) begin
         iimg_nxt = in_s & in_mask(ctrl_r[`CTL_F_VAR +: 2]);
         ev[`CTL_E_INCHG] = iimg_nxt != iimg_r;
         if (ctrl_r[`CTL_F_RUN] && !err_r) begin
            out_nxt = oimg_r & out_mask(ctrl_r[`CTL_F_VAR +: 2]);
         end
      end
      if (err_r || !ctrl_r[`CTL_F_RUN]) begin
         out_nxt = '0;
      end
      if (ctrl_r[`CTL_F_DRUM]) begin
         if (in_s[1]) begin
            drum_nxt = '0;
         end else if (in_s[0] && !d0p_r && !err_r) begin
            drum_nxt = drum_r + 16'h1;
         end
         ev[`CTL_E_DRUMRST] = in_s[1] && !d1p_r;
      end
      ev[`CTL_E_ERR]      = diag_s && !err_r;
      ev[`CTL_E_LINKLOST] = okp_r && !rly.ok;
   end

   // axi4-lite slave and register writes
   always_comb begin
      aw_nxt = aw_r;
      w_nxt = w_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bv_nxt = s_axi_bvalid;
      br_nxt = s_axi_bresp;
      rv_nxt = s_axi_rvalid;
      rr_nxt = s_axi_rresp;
      rd_nxt = s_axi_rdata;
      ctrl_nxt = ctrl_r;
      oimg_nxt = oimg_r;
      own_nxt = own_r;
      imask_nxt = imask_r;
      ist_nxt = ist_r;
      wv = '0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
         ws_nxt = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) bv_nxt = 1'b0;
      if (do_wr) begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = 2'h0;
         if (awa_r == `CTL_A_CTRL) begin
            ctrl_nxt = 4'(wmerge({28'h0, ctrl_r}, wd_r, ws_r));
         end else if (awa_r == `CTL_A_OUT) begin
            oimg_nxt = 8'(wmerge({24'h0, oimg_r}, wd_r, ws_r));
         end else if (awa_r == `CTL_A_LROWN) begin
            own_nxt = wmerge(own_r, wd_r, ws_r);
         end else if (awa_r == `CTL_A_IMASK) begin
            imask_nxt = 4'(wmerge({28'h0, imask_r}, wd_r, ws_r));
         end else if (awa_r == `CTL_A_ISTAT) begin
            wv = wmerge('0, wd_r, ws_r);
            ist_nxt = ist_r & ~wv[3:0];
         end else if (awa_r == `CTL_A_STAT || awa_r == `CTL_A_IN || awa_r == `CTL_A_DRUM
                      || (awa_r >= `CTL_A_LR0 && awa_r <= `CTL_A_LR3 && awa_r[1:0] == 2'h0)) begin
            br_nxt = 2'h0;
         end else begin
            br_nxt = 2'h2;
         end
      end
      ist_nxt = ist_nxt | ev; // set wins over clear
      if (s_axi_rvalid && s_axi_rready) rv_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rv_nxt = 1'b1;
         rr_nxt = 2'h0;
         rd_nxt = '0;
         if (s_axi_araddr == `CTL_A_CTRL) begin
            rd_nxt[3:0] = ctrl_r;
         end else if (s_axi_araddr == `CTL_A_STAT) begin
            rd_nxt[`CTL_S_ERR] = err_r;
            rd_nxt[`CTL_S_LINK] = rly.ok;
            rd_nxt[`CTL_S_MST] = rly.master;
            rd_nxt[`CTL_S_UNIT +: 2] = rly.unit;
         end else if (s_axi_araddr == `CTL_A_IN) begin
            rd_nxt[11:0] = iimg_r;
         end else if (s_axi_araddr == `CTL_A_OUT) begin
            rd_nxt[7:0] = oimg_r;
         end else if (s_axi_araddr == `CTL_A_DRUM) begin
            rd_nxt[15:0] = drum_r;
         end else if (s_axi_araddr == `CTL_A_LROWN) begin
            rd_nxt = own_r;
         end else if (s_axi_araddr >= `CTL_A_LR0 && s_axi_araddr <= `CTL_A_LR3
                      && s_axi_araddr[1:0] == 2'h0) begin
            rd_nxt = rly.img[2'(s_axi_araddr[7:2] - 6'(`CTL_A_LR0 >> 2))];
         end else if (s_axi_araddr == `CTL_A_ISTAT) begin
            rd_nxt[3:0] = ist_r;
         end else if (s_axi_araddr == `CTL_A_IMASK) begin
            rd_nxt[3:0] = imask_r;
         end else begin
            rr_nxt = 2'h2;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_r <= '0;
         iimg_r <= '0;
         out_pt <= '0;
         drum_r <= '0;
         err_r <= 1'b0;
         okp_r <= 1'b0;
         d0p_r <= 1'b0;
         d1p_r <= 1'b0;
         led_run <= 1'b0;
         led_link <= 1'b0;
         led_err <= 1'b0;
         irq <= 1'b0;
         aw_r <= 1'b0;
         w_r <= 1'b0;
         awa_r <= '0;
         wd_r <= '0;
         ws_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= '0;
         s_axi_rdata <= '0;
         ctrl_r <= '0;
         oimg_r <= '0;
         own_r <= '0;
         imask_r <= '0;
         ist_r <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_arready <= 1'b1;
      end else begin
         scan_r <= scan_nxt;
         iimg_r <= iimg_nxt;
         out_pt <= out_nxt;
         drum_r <= drum_nxt;
         err_r <= err_nxt;
         okp_r <= rly.ok;
         d0p_r <= in_s[0];
         d1p_r <= in_s[1];
         led_run <= ctrl_nxt[`CTL_F_RUN] && !err_nxt;
         led_link <= rly.ok;
         led_err <= err_nxt;
         irq <= |(ist_nxt & imask_nxt);
         aw_r <= aw_nxt;
         w_r <= w_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         s_axi_bvalid <= bv_nxt;
         s_axi_bresp <= br_nxt;
         s_axi_rvalid <= rv_nxt;
         s_axi_rresp <= rr_nxt;
         s_axi_rdata <= rd_nxt;
         ctrl_r <= ctrl_nxt;
         oimg_r <= oimg_nxt;
         own_r <= own_nxt;
         imask_r <= imask_nxt;
         ist_r <= ist_nxt;
         s_axi_awready <= !aw_nxt;
         s_axi_wready <= !w_nxt;
         s_axi_arready <= !rv_nxt;
      end
   end

   sequence s_fault_seen;
      !err_r ##1 err_r;
   endsequence
   sequence s_drum_pulse;
      ctrl_r[`CTL_F_DRUM] && !in_s[1] && in_s[0] && !d0p_r && !err_r;
   endsequence
   a_in_sample: assert property (@(posedge aclk) disable iff (!aresetn)
      tick |=> iimg_r == ($past(in_s) & in_mask($past(ctrl_r[3:2])))) else $error("input image not sampled");
   a_out_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && ctrl_r[`CTL_F_RUN] && !err_r) |=> out_pt == ($past(oimg_r) & out_mask($past(ctrl_r[3:2]))))
      else $error("output points not driven from image");
   a_drum_count: assert property (@(posedge aclk) disable iff (!aresetn)
      s_drum_pulse |=> drum_r == $past(drum_r) + 16'h1) else $error("drum counter missed a count");
   a_drum_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_r[`CTL_F_DRUM] && in_s[1]) |=> drum_r == '0) else $error("drum counter not reset");
   a_run_lamp: assert property (@(posedge aclk) disable iff (!aresetn)
      led_run |-> (ctrl_r[`CTL_F_RUN] && !err_r)) else $error("run lamp lit outside normal run");
   a_link_lamp: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(rly.ok) |=> !led_link) else $error("link lamp stayed lit after link loss");
   a_fault_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fault_seen |=> (led_err && !led_run && out_pt == '0)) else $error("fault did not stop operation");
   a_point_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      (out_pt & ~out_mask(ctrl_r[3:2])) == '0 || $changed(ctrl_r)) else $error("absent output point driven");
endmodule : ctl_top

// ### sim/controller_io_image_and_link_tb.sv
// testbench of the controller core with linked peers
`include "ctl_map.svh"
module controller_io_image_and_link_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, diag_fault, led_run, led_link, led_err, irq, slow;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, out_pt;
   logic [31:0] s_axi_wdata, s_axi_rdata, lk_dat_i, lk_dat_o;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, unit_pin, lk_sel_i, lk_sel_o;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        lk_stb_i, lk_stb_o, lk_stb_oe, lk_sel_oe, lk_ack_i, lk_ack_o, lk_ack_oe, lk_dat_oe;
   logic [11:0] in_pt;
   int          error_cnt = 0;
   int          samples_checked = 0;

   ctl_top u_dut (.*);
   ctl_peer_model u_peer (.aclk(aclk), .slow(slow), .stb_o(lk_stb_o), .stb_oe(lk_stb_oe), .sel_o(lk_sel_o),
      .sel_oe(lk_sel_oe), .ack_o(lk_ack_o), .ack_oe(lk_ack_oe), .dat_o(lk_dat_o), .dat_oe(lk_dat_oe),
      .stb_w(lk_stb_i), .sel_w(lk_sel_i), .ack_w(lk_ack_i), .dat_w(lk_dat_i));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata & m, exp);
      chk(32'(s_axi_rresp), 32'(er));
   endtask : rd_chk

   task automatic scan();
      repeat (1100) @(posedge aclk);
   endtask : scan

   task automatic t_regs();
      rd_chk(`CTL_A_CTRL, 32'hFFFF_FFFF, 32'h0, 2'h0);
      rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0, 2'h2);
      wr(8'h40, 32'h1, 2'h2);
      wr(`CTL_A_IN, 32'hFFF, 2'h0);
      rd_chk(`CTL_A_IN, 32'hFFFF_FFFF, 32'h0, 2'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_io();
      logic [11:0] im [3] = '{12'h03F, 12'h3FF, 12'hFFF};
      logic [8:0]  om [3] = '{9'h10F, 9'h13F, 9'h1FF};
      logic [11:0] pat;
      for (int v = 0; v < 3; v++) begin
         pat = v[0] ? 12'hA5B : 12'hFFF;
         in_pt <= pat;
         wr(`CTL_A_OUT, 32'hFF, 2'h0);
         wr(`CTL_A_CTRL, 32'(v * 4 + 1), 2'h0);
         scan();
         rd_chk(`CTL_A_IN, 32'hFFFF_FFFF, 32'(pat & im[v]), 2'h0);
         chk(32'({led_run, out_pt}), 32'(om[v]));
      end
      wr(`CTL_A_CTRL, 32'h8, 2'h0);
      scan();
      chk(32'({led_run, out_pt}), 32'h0);
      $display("test io done");
   endtask : t_io

   task automatic t_drum();
      wr(`CTL_A_CTRL, 32'hA, 2'h0);
      in_pt <= 12'h0;
      repeat (20) @(posedge aclk);
      wr(`CTL_A_ISTAT, 32'hF, 2'h0);
      repeat (3) begin
         in_pt <= 12'h1;
         repeat (10) @(posedge aclk);
         in_pt <= 12'h0;
         repeat (10) @(posedge aclk);
      end
      rd_chk(`CTL_A_DRUM, 32'hFFFF, 32'h3, 2'h0);
      in_pt <= 12'h2;
      repeat (10) @(posedge aclk);
      rd_chk(`CTL_A_DRUM, 32'hFFFF, 32'h0, 2'h0);
      rd_chk(`CTL_A_ISTAT, 32'h2, 32'h2, 2'h0);
      $display("test drum done");
   endtask : t_drum

   task automatic t_irq();
      wr(`CTL_A_IMASK, 32'h0, 2'h0);
      wr(`CTL_A_ISTAT, 32'hF, 2'h0);
      in_pt <= 12'h0F2;
      scan();
      rd_chk(`CTL_A_ISTAT, 32'h1, 32'h1, 2'h0);
      chk(32'(irq), 32'h0);
      wr(`CTL_A_IMASK, 32'h1, 2'h0);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h1);
      wr(`CTL_A_ISTAT, 32'h1, 2'h0);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0);
      rd_chk(`CTL_A_ISTAT, 32'h1, 32'h0, 2'h0);
      $display("test irq done");
   endtask : t_irq

   task automatic t_link(input logic sl, input logic [31:0] own);
      slow <= sl;
      wr(`CTL_A_LROWN, own, 2'h0);
      repeat (3) scan();
      rd_chk(`CTL_A_STAT, 32'h37, 32'h6, 2'h0);
      chk(32'(led_link), 32'h1);
      rd_chk(`CTL_A_LR0, 32'hFFFF_FFFF, own, 2'h0);
      for (int s = 1; s < 4; s++) begin
         rd_chk(`CTL_A_LR0 + 8'(4 * s), 32'hFFFF_FFFF, 32'hC0DE_0000 | 32'(s), 2'h0);
      end
      $display("test link done");
   endtask : t_link

   task automatic t_fault();
      wr(`CTL_A_OUT, 32'hFF, 2'h0);
      wr(`CTL_A_CTRL, 32'h9, 2'h0);
      scan();
      chk(32'({led_err, led_run, out_pt}), 32'h1FF);
      diag_fault <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(32'({led_err, led_run, out_pt}), 32'h200);
      rd_chk(`CTL_A_STAT, 32'h1, 32'h1, 2'h0);
      diag_fault <= 1'b0;
      scan();
      chk(32'({led_err, led_run, out_pt}), 32'h200);
      $display("test fault done");
   endtask : t_fault

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #400us;
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {diag_fault, slow} = 2'h0;
      in_pt = 12'h000;
      unit_pin = 2'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
      t_regs();
      t_io();
      t_drum();
      t_irq();
      t_link(1'b0, 32'h1234_ABCD);
      t_link(1'b1, 32'h5A5A_0F0F);
      t_fault();
      tally_and_finish();
   end
endmodule : controller_io_image_and_link_tb

// ### sim/ctl_peer_model.sv
// link peers for units 1 to 3 plus the wired link bus
module ctl_peer_model (
   // clock and answer speed
   input  wire logic        aclk,
   input  wire logic        slow,
   // design link pin drivers
   input  wire logic        stb_o,
   input  wire logic        stb_oe,
   input  wire logic [1:0]  sel_o,
   input  wire logic        sel_oe,
   input  wire logic        ack_o,
   input  wire logic        ack_oe,
   input  wire logic [31:0] dat_o,
   input  wire logic        dat_oe,
   // resolved bus levels
   output logic             stb_w,
   output logic [1:0]       sel_w,
   output logic             ack_w,
   output logic [31:0]      dat_w
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        drv_r  = 1'b0;
   logic        ack_r  = 1'b0;
   logic [3:0]  wait_r = 4'h0;
   logic [31:0] idle_r = 32'h0;
   logic        polled;
   // a peer answers only when the master strobes its slot
   assign polled = stb_w && sel_w != 2'h0;
   assign stb_w  = stb_oe & stb_o;
   assign sel_w  = sel_oe ? sel_o : idle_r[1:0];
   assign ack_w  = (ack_oe & ack_o) | ack_r;
   // released data lines wander so a stale word never passes
   assign dat_w  = dat_oe ? dat_o : drv_r ? {30'h3037_8000, sel_w} : ~idle_r;
   always @(posedge aclk) begin
      idle_r <= idle_r + 32'h1;
      drv_r  <= polled;
      wait_r <= polled ? wait_r + 4'h1 : 4'h0;
      ack_r  <= polled && (ack_r || wait_r == (slow ? 4'h5 : 4'h1));
   end
endmodule : ctl_peer_model
